// File: core/kbi_regs.svh
`ifndef KBI_REGS_SVH
`define KBI_REGS_SVH

// ****************************************
// Register addresses on the SFR bus
// ****************************************
`define KBI_ADDR_LEVEL_SELECT 8'h9C
`define KBI_ADDR_LINE_ENABLE  8'h9D
`define KBI_ADDR_LINE_FLAGS   8'h9E

// ****************************************
// Reset values
// ****************************************
`define KBI_RST_LEVEL_SELECT  8'h00
`define KBI_RST_LINE_ENABLE   8'h00
`define KBI_RST_LINE_FLAGS    8'h00
`define KBI_RST_RDATA         8'h00

// ****************************************
// Widths
// ****************************************
`define KBI_LINES             8
`define KBI_ADDR_W            8
`define KBI_DATA_W            8

`endif

// File: core/kbi_pkg.sv
`include "kbi_regs.svh"

package kbi_pkg;

    // ****************************************
    // SFR access request
    // ****************************************
    typedef struct packed {
        logic [`KBI_ADDR_W-1:0] addr;
        logic                   wr;
        logic                   rd;
        logic [`KBI_DATA_W-1:0] wdata;
    } kbi_sfr_req_t;

    // ****************************************
    // Read answer
    // ****************************************
    typedef struct packed {
        logic                   hit;
        logic [`KBI_DATA_W-1:0] rdata;
    } kbi_sfr_rsp_t;

endpackage

// File: core/kbi_line.sv
`timescale 1ns/1ns

// One keyboard line: level match and sticky flag
module kbi_line (
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    input  wire logic i_pin,
    input  wire logic i_level_sel,
    input  wire logic i_clear,
    output logic      o_flag
);

    logic match;
    logic flag_r;
    logic flag_nxt;

    // [RULE_04] level compare
    assign match = (i_pin == i_level_sel);

    // [RULE_12] set wins over clear
    assign flag_nxt = (i_clear ? 1'b0 : flag_r) | match;

    // [RULE_05] sticky flag per line
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign o_flag = flag_r;

endmodule

// File: core/kbi_top.sv
`timescale 1ns/1ns
`include "kbi_regs.svh"

// Summary of operation
// [RULE_01] Eight key lines from the port each raise a request on a chosen high or low level.
// [RULE_02] All eight lines share one common interrupt request.
// [RULE_03] The combined request reaches the core only while the global keypad enable is set.
// [RULE_04] A level select bit of 0 detects low, 1 detects high, per line.
// [RULE_05] Flag bit n is set by hardware when line n shows its programmed level.
// [RULE_06] A flag contributes to the request only while its line enable bit is 1.
// [RULE_07] A line with enable 0 stays an ordinary port pin.
// [RULE_08] The flag register is read only and any read clears all eight flags.
// [RULE_09] An enabled level detection wakes the core from idle and power-down.
// [RULE_10] Unused lines stay free for other uses, serving one to eight rows.
// [RULE_11] Reset clears flags, enables and level selects to zero.
// [RULE_12] A level still present after a clear sets the flag again.
module kbi_top #(
    parameter int LINES = `KBI_LINES
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_srst,
    input  wire logic [LINES-1:0]      i_port_one_lines,
    input  wire logic                  i_keypad_global_irq_enable,
    input  wire kbi_pkg::kbi_sfr_req_t i_sfr_req,
    output kbi_pkg::kbi_sfr_rsp_t      o_sfr_rsp,
    output logic      [LINES-1:0]      o_key_line_enable,
    output logic                       o_key_irq,
    output logic                       o_wake_req
);

    // ****************************************
    // Registers
    // ****************************************
    logic [LINES-1:0]      key_level_select_r;
    logic [LINES-1:0]      key_line_enable_r;
    logic [LINES-1:0]      key_line_flags;
    logic [LINES-1:0]      pending;
    logic                  sel_level;
    logic                  sel_enable;
    logic                  sel_flags;
    logic                  flags_clear;
    kbi_pkg::kbi_sfr_rsp_t rsp_r;
    kbi_pkg::kbi_sfr_rsp_t rsp_nxt;
    logic                  irq_r;
    logic                  wake_r;

    assign sel_level  = (i_sfr_req.addr == `KBI_ADDR_LEVEL_SELECT);
    assign sel_enable = (i_sfr_req.addr == `KBI_ADDR_LINE_ENABLE);
    assign sel_flags  = (i_sfr_req.addr == `KBI_ADDR_LINE_FLAGS);

    // [RULE_08] read clears all flags
    assign flags_clear = i_sfr_req.rd & sel_flags;

    // ****************************************
    // Configuration writes
    // ****************************************
    // [RULE_11] zero after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            key_level_select_r <= LINES'(`KBI_RST_LEVEL_SELECT);
        end else if (i_sfr_req.wr && sel_level) begin
            key_level_select_r <= i_sfr_req.wdata[LINES-1:0];
        end
    end

    // [RULE_11] zero after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            key_line_enable_r <= LINES'(`KBI_RST_LINE_ENABLE);
        end else if (i_sfr_req.wr && sel_enable) begin
            key_line_enable_r <= i_sfr_req.wdata[LINES-1:0];
        end
    end

    // ****************************************
    // Per-line detectors
    // ****************************************
    // [RULE_01] eight independent detectors
    for (genvar n = 0; n < LINES; n++) begin : g_line
        kbi_line u_line (
            .i_sys_clk   (i_sys_clk),
            .i_srst      (i_srst),
            .i_pin       (i_port_one_lines[n]),
            .i_level_sel (key_level_select_r[n]),
            .i_clear     (flags_clear),
            .o_flag      (key_line_flags[n])
        );
    end

    // [RULE_06] mask by line enable
    assign pending = key_line_flags & key_line_enable_r;

    // ****************************************
    // Read path
    // ****************************************
    // Flag writes are ignored: register is read only
    always_comb begin
        rsp_nxt = '0;
        if (i_sfr_req.rd) begin
            rsp_nxt.hit = sel_level | sel_enable | sel_flags;
            if (sel_level) begin
                rsp_nxt.rdata = `KBI_DATA_W'(key_level_select_r);
            end else if (sel_enable) begin
                rsp_nxt.rdata = `KBI_DATA_W'(key_line_enable_r);
            end else if (sel_flags) begin
                rsp_nxt.rdata = `KBI_DATA_W'(key_line_flags);
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            rsp_r <= '0;
        end else begin
            rsp_r <= rsp_nxt;
        end
    end

    // ****************************************
    // Request and wake
    // ****************************************
    // [RULE_02] [RULE_03] shared request, global gate
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= i_keypad_global_irq_enable & (|pending);
        end
    end

    // [RULE_09] wake from idle and power-down
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wake_r <= 1'b0;
        end else begin
            wake_r <= |pending;
        end
    end

    // [RULE_07] [RULE_10] enable tells port which lines are keys
    assign o_key_line_enable = key_line_enable_r;
    assign o_sfr_rsp         = rsp_r;
    assign o_key_irq         = irq_r;
    assign o_wake_req        = wake_r;

endmodule

// File: test/kbi_keys.sv
`timescale 1ns/1ns
module kbi_keys (
    input  wire logic [7:0] i_pressed,
    output logic      [7:0] o_lines
);
    // Closed key grounds its line, pull-up holds it high otherwise
    assign o_lines = ~i_pressed;
endmodule

// File: test/kbi_props.sv
`timescale 1ns/1ns
module kbi_props #(
    parameter int LINES = 8
) (
    input wire logic                  i_sys_clk,
    input wire logic                  i_srst,
    input wire logic [LINES-1:0]      i_port_one_lines,
    input wire logic                  i_keypad_global_irq_enable,
    input wire kbi_pkg::kbi_sfr_req_t i_sfr_req,
    input wire kbi_pkg::kbi_sfr_rsp_t o_sfr_rsp,
    input wire logic [LINES-1:0]      o_key_line_enable,
    input wire logic                  o_key_irq,
    input wire logic                  o_wake_req
);
    logic [LINES-1:0] ls_r;
    logic [LINES-1:0] m;
    // Shadow of level select, needed to predict line matches
    always_ff @(posedge i_sys_clk) begin
        ls_r <= i_srst ? '0 : (i_sfr_req.wr && i_sfr_req.addr == 8'h9C) ? i_sfr_req.wdata : ls_r;
    end
    assign m = ~(i_port_one_lines ^ ls_r);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    glob_gate_a: assert property (
        !i_keypad_global_irq_enable |=> !o_key_irq) else $error("irq without global enable");
    irq_wake_a: assert property (
        o_key_irq |-> o_wake_req) else $error("irq without pending line");
    mask_all_a: assert property (
        o_key_line_enable == '0 |=> !o_wake_req) else $error("masked flag requests");
    flag_set_a: assert property (
        i_sfr_req.rd && i_sfr_req.addr == 8'h9E && !$past(i_srst) |=> o_sfr_rsp.hit
        && (o_sfr_rsp.rdata & $past(m, 2)) == $past(m, 2)) else $error("flag missing");
    wake_hit_a: assert property (
        (m & o_key_line_enable) != '0 && !i_sfr_req.wr |=> ##1 o_wake_req) else $error("no wake");
    en_write_a: assert property (
        i_sfr_req.wr && i_sfr_req.addr == 8'h9D
        |=> o_key_line_enable == $past(i_sfr_req.wdata)) else $error("enable write lost");
    lvl_read_a: assert property (
        i_sfr_req.rd && i_sfr_req.addr == 8'h9C
        |=> o_sfr_rsp.hit && o_sfr_rsp.rdata == $past(ls_r)) else $error("level read wrong");
    reset_val_a: assert property (disable iff (1'b0)
        i_srst |=> o_key_line_enable == '0 && !o_key_irq && !o_wake_req) else $error("reset");
endmodule
bind kbi_top kbi_props #(.LINES(LINES)) u_props (.i_sys_clk, .i_srst, .i_port_one_lines,
    .i_keypad_global_irq_enable, .i_sfr_req, .o_sfr_rsp, .o_key_line_enable, .o_key_irq,
    .o_wake_req);

// File: test/kbi_top_tb.sv
`timescale 1ns/1ns
module kbi_top_tb;
    logic                  clk = 0;
    logic                  srst = 1;
    logic                  glob = 0;
    logic                  irq;
    logic                  wake;
    logic [7:0]            key_en;
    logic [7:0]            press = 8'h00;
    logic [7:0]            lines;
    kbi_pkg::kbi_sfr_req_t req = '0;
    kbi_pkg::kbi_sfr_rsp_t rsp;
    kbi_pkg::kbi_sfr_rsp_t got;
    int                    error_cnt = 0;
    int                    n_checks = 0;
    // Level select, enable, pressed keys, global, flags, irq
    logic [33:0]           rows [5] = '{
        {8'h00, 8'h01, 8'h01, 1'h1, 8'h01, 1'h1},
        {8'hFF, 8'h80, 8'h7F, 1'h1, 8'h80, 1'h1},
        {8'h00, 8'h0F, 8'hF0, 1'h1, 8'hF0, 1'h0},
        {8'h0F, 8'hFF, 8'h00, 1'h0, 8'h0F, 1'h0},
        {8'hA5, 8'h5A, 8'h0F, 1'h1, 8'hAA, 1'h1}};
    always #25 clk = ~clk;
    kbi_keys keys (.i_pressed(press), .o_lines(lines));
    kbi_top dut (.i_sys_clk(clk), .i_srst(srst), .i_port_one_lines(lines),
        .i_keypad_global_irq_enable(glob), .i_sfr_req(req), .o_sfr_rsp(rsp),
        .o_key_line_enable(key_en), .o_key_irq(irq), .o_wake_req(wake));
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        req = {a, w, !w, d};
        @(posedge clk) #1;
        req = '0;
        got = rsp;
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #50000;
        error_cnt++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge clk);
        #1 srst = 0;
        foreach (rows[i]) begin
            bus(1'b1, 8'h9C, rows[i][33:26]);
            bus(1'b1, 8'h9D, rows[i][25:18]);
            press = rows[i][17:10];
            glob = rows[i][9];
            // First read drops stale flags, level still present sets them again
            bus(1'b0, 8'h9E, 8'h00);
            bus(1'b0, 8'h9E, 8'h00);
            chk("flags", {1'b1, rows[i][8:1]}, got);
            chk("irq", {8'h00, rows[i][0]}, irq);
            // Wake ignores the global enable, row 3 proves it
            chk("wake", {8'h00, |(rows[i][8:1] & rows[i][25:18])}, wake);
            chk("enable out", {1'b0, rows[i][25:18]}, key_en);
        end
        bus(1'b1, 8'h9C, 8'h00);
        press = 8'h00;
        bus(1'b0, 8'h9E, 8'h00);
        bus(1'b1, 8'h9E, 8'hFF);
        bus(1'b0, 8'h9E, 8'h00);
        chk("cleared", 9'h100, got);
        chk("irq off", 9'h000, irq);
        bus(1'b0, 8'h9F, 8'h00);
        chk("unmapped", 9'h000, got);
        srst = 1;
        repeat (2) @(posedge clk);
        #1 srst = 0;
        bus(1'b0, 8'h9D, 8'h00);
        chk("enable rst", 9'h100, got);
        // Flag sets with enable still zero, but nothing may leave the block
        press = 8'h01;
        bus(1'b0, 8'h9E, 8'h00);
        bus(1'b0, 8'h9E, 8'h00);
        chk("masked flags", 9'h101, got);
        chk("masked irq", 9'h000, irq);
        chk("masked wake", 9'h000, wake);
        end_sim;
    end
endmodule
